// ---- hw/tdl_clkdiv.sv ----
`timescale 1ns/1ps
module tdl_clkdiv #(
   parameter int HALF_CYCLES = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic link_clk,
   output logic rise,
   output logic fall
);
   localparam int CW = $clog2(HALF_CYCLES + 1);
   logic [CW-1:0] cnt, next_cnt;
   logic next_link_clk;
   logic wrap;

   assign wrap = (cnt == CW'(HALF_CYCLES - 1));
   // pulses mark the cycle in which link_clk changes on the next edge
   assign rise = run && wrap && !link_clk;
   assign fall = run && wrap && link_clk;

   always_comb begin
      next_cnt = '0;
      next_link_clk = link_clk;
      if (run) begin
         next_cnt = wrap ? '0 : cnt + 1'b1;
         if (wrap) begin
            next_link_clk = !link_clk;
         end
      end else begin
         // stopped clock always parks low
         next_link_clk = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= '0;
         link_clk <= 1'b0;
      end else begin
         cnt <= next_cnt;
         link_clk <= next_link_clk;
      end
   end
endmodule

// ---- hw/tdl_fifo.sv ----
`timescale 1ns/1ps
module tdl_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] level, next_level;
   logic push, pop;

   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level = level;
      if (push) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_level = level + 1'b1;
      end else if (pop && !push) begin
         next_level = level - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      mem <= next_mem;
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
   end
endmodule

// ---- hw/tdl_host.sv ----
`timescale 1ns/1ps
module tdl_host import tdl_pkg::*; #(
   parameter int NUM_CONV = 4,
   parameter int POR_LEN = POR_CYCLES,
   parameter int HALF_LEN = LINK_HALF_CYCLES,
   parameter int SETTLE_LEN = SETTLE_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic word_valid,
   output logic word_ready,
   input wire tdl_word_type word_data,
   input wire logic isolated_mode,
   input wire logic clear_req,
   output logic busy,
   output logic word_done,
   output logic link_clk,
   output logic serial_bit_in,
   output logic conv_clk,
   output logic transfer_strobe_n,
   output logic output_clear_n,
   output logic [NUM_CONV-1:0] conv_select_n,
   output logic limit_converter_select
);
   localparam int PW = $clog2(POR_LEN + 1);
   localparam int SW = $clog2(SETTLE_LEN + 1);

   tdl_state_type state, next_state;
   logic [PW-1:0] por_cnt, next_por_cnt;
   logic [SW-1:0] settle_cnt, next_settle_cnt;
   logic [PULSE_W-1:0] pulses, next_pulses;
   logic [DATA_BITS-1:0] shreg, next_shreg;
   logic next_serial_bit_in;
   logic [TGT_W-1:0] target, next_target;
   logic decode_en, next_decode_en;
   logic next_limit_sel;
   logic next_word_done;
   logic [CNT_W-1:0] edge_cnt, next_edge_cnt;
   logic next_strobe_n;
   logic next_clear_n;
   logic [NUM_CONV-1:0] next_select_n;
   logic in_word, next_in_word;
   logic run, rise, fall;
   logic fifo_valid, fifo_ready;
   tdl_word_type fifo_word;

   tdl_fifo #(
      .WIDTH($bits(tdl_word_type)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(word_valid),
      .in_ready(word_ready),
      .in_data(word_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_word)
   );

   tdl_clkdiv #(
      .HALF_CYCLES(HALF_LEN)
   ) u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(run),
      .link_clk(link_clk),
      .rise(rise),
      .fall(fall)
   );

   // the clock runs only while shifting; it is never stopped high
   // a clock parked high would leave the converter clock low, and the
   // next release of a select line could then shift a stray bit
   assign run = (state == ST_SHIFT);
   assign fifo_ready = (state == ST_IDLE) && !clear_req;
   assign busy = (state != ST_IDLE);
   assign conv_clk = !link_clk;

   // sequencer
   always_comb begin
      next_state = state;
      next_por_cnt = por_cnt;
      next_settle_cnt = settle_cnt;
      next_pulses = pulses;
      next_shreg = shreg;
      next_serial_bit_in = serial_bit_in;
      next_target = target;
      next_decode_en = decode_en;
      next_limit_sel = limit_converter_select;
      next_word_done = 1'b0;
      next_in_word = in_word;
      unique case (state)
         ST_POR: begin
            // clear held well past the supply ramp
            if (por_cnt == PW'(POR_LEN - 1)) begin
               next_state = ST_IDLE;
            end else begin
               next_por_cnt = por_cnt + 1'b1;
            end
         end
         ST_IDLE: begin
            if (fifo_valid && !clear_req) begin
               next_target = fifo_word.target;
               next_limit_sel = fifo_word.target[0];
               next_shreg = fifo_word.code;
               next_settle_cnt = '0;
               next_decode_en = 1'b0;
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            // address lines settle before decoding is enabled
            if (settle_cnt == SW'(SETTLE_LEN - 1)) begin
               next_decode_en = 1'b1;
               next_pulses = PULSE_ZERO;
               next_in_word = 1'b1;
               next_state = ST_SHIFT;
            end else begin
               next_settle_cnt = settle_cnt + 1'b1;
            end
         end
         ST_SHIFT: begin
            if (rise) begin
               next_pulses = pulses + 1'b1;
               // msb first; the value stands across the following fall
               if (pulses < PULSE_W'(DATA_BITS)) begin
                  next_serial_bit_in = shreg[DATA_BITS-1];
                  next_shreg = {shreg[DATA_BITS-2:0], 1'b0};
               end
            end
            // stop once the 13th pulse has fallen back to rest
            if (fall && pulses == PULSES_PER_WORD) begin
               next_in_word = 1'b0;
               next_settle_cnt = '0;
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // link clock already low here, so the converter clock is high
            if (settle_cnt == SW'(SETTLE_LEN - 1)) begin
               next_decode_en = 1'b0;
               next_word_done = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_settle_cnt = settle_cnt + 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // a clear never cuts a word in flight: the strobe must still come,
      // else the converter would keep a half shifted word for the next load
      if (clear_req && state != ST_POR && state != ST_SHIFT) begin
         next_decode_en = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_POR;
         por_cnt <= '0;
         settle_cnt <= '0;
         pulses <= PULSE_ZERO;
         shreg <= '0;
         serial_bit_in <= 1'b0;
         target <= '0;
         decode_en <= 1'b0;
         limit_converter_select <= 1'b0;
         word_done <= 1'b0;
         in_word <= 1'b0;
      end else begin
         state <= next_state;
         por_cnt <= next_por_cnt;
         settle_cnt <= next_settle_cnt;
         pulses <= next_pulses;
         shreg <= next_shreg;
         serial_bit_in <= next_serial_bit_in;
         target <= next_target;
         decode_en <= next_decode_en;
         limit_converter_select <= next_limit_sel;
         word_done <= next_word_done;
         in_word <= next_in_word;
      end
   end

   // glue counter, stepped by the link clock rising edge
   always_comb begin
      next_edge_cnt = edge_cnt;
      if (state == ST_POR) begin
         next_edge_cnt = CNT_ZERO;
      end else if (!next_in_word) begin
         // resting link returns the count to zero for the next word
         // taken from the next word flag so that the strobe ends on the
         // same edge as the 13th fall, not one system cycle later
         next_edge_cnt = CNT_ZERO;
      end else if (rise) begin
         // the first rise of a word or a low strobe reloads zero
         if (!transfer_strobe_n || pulses == PULSE_ZERO) begin
            next_edge_cnt = CNT_ZERO;
         end else begin
            next_edge_cnt = edge_cnt + 1'b1;
         end
      end
      // count reads CNT_LAST_BIT after bit twelve; next rise hits strobe
      next_strobe_n = !(next_edge_cnt == CNT_STROBE);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         edge_cnt <= CNT_ZERO;
         transfer_strobe_n <= 1'b1;
      end else begin
         edge_cnt <= next_edge_cnt;
         transfer_strobe_n <= next_strobe_n;
      end
   end

   // clear and select pins
   // selects are registered so the decoded lines never glitch while the
   // target changes; isolated mode ignores the target on conv_select_n, not on limit_converter_select
   always_comb begin
      // low through power-on and on demand, independent of the link
      next_clear_n = !(state == ST_POR || clear_req);
      next_select_n = '1;
      if (isolated_mode) begin
         next_select_n = '0;
      end else if (decode_en) begin
         next_select_n[target] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         output_clear_n <= 1'b0;
         conv_select_n <= '1;
      end else begin
         output_clear_n <= next_clear_n;
         conv_select_n <= next_select_n;
      end
   end
endmodule

// ---- shared/tdl_pkg.sv ----
package tdl_pkg;
   localparam int DATA_BITS = 12;
   localparam int CNT_W = 4;
   localparam int TGT_W = 2;
   localparam int PULSE_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_LAST_BIT = 4'hb;
   localparam logic [CNT_W-1:0] CNT_STROBE = 4'hc;
   localparam logic [PULSE_W-1:0] PULSES_PER_WORD = 4'hd;
   localparam logic [PULSE_W-1:0] PULSE_ZERO = 4'h0;
   localparam int CLK_PERIOD_NS = 10;
   // least high and low time of the link clock
   localparam int LINK_HALF_NS = 200;
   localparam int LINK_HALF_CYCLES =
      (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // address settle before the decoder is enabled
   localparam int SETTLE_NS = 50;
   localparam int SETTLE_CYCLES =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_MS = 10;
   localparam longint POR_CYCLES_L =
      longint'(POR_MS) * 64'd1000000 / longint'(CLK_PERIOD_NS);
   localparam int POR_CYCLES = int'(POR_CYCLES_L);
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [TGT_W-1:0] target;
      logic [DATA_BITS-1:0] code;
   } tdl_word_type;

   typedef enum logic [2:0] {
      ST_POR = 3'b000,
      ST_IDLE = 3'b001,
      ST_ADDR = 3'b010,
      ST_SHIFT = 3'b011,
      ST_RELEASE = 3'b100
   } tdl_state_type;
endpackage

// ---- sim/tdl_conv_model.sv ----
`timescale 1ns/1ps
module tdl_conv_model import tdl_pkg::*; (
   input wire logic conv_clk,
   input wire logic serial_bit_in,
   input wire logic transfer_strobe_n,
   input wire logic output_clear_n,
   input wire logic select_n,
   output logic [DATA_BITS-1:0] level
);
   logic [DATA_BITS-1:0] shift_reg;
   always @(posedge conv_clk) begin
      if (!select_n) begin
         shift_reg <= {shift_reg[DATA_BITS-2:0], serial_bit_in};
      end
   end
   // copy taken as the strobe falls, so a later shift cannot leak in
   always @(negedge transfer_strobe_n or negedge output_clear_n) begin
      if (!output_clear_n) begin
         level <= '0;
      end else if (!select_n) begin
         level <= shift_reg;
      end
   end
endmodule

// ---- sim/tdl_host_asserts.sv ----
`timescale 1ns/1ps
module tdl_host_asserts #(
   parameter int NUM_CONV = 4,
   parameter int POR_LEN = 50
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic isolated_mode,
   input wire logic clear_req,
   input wire logic busy,
   input wire logic word_done,
   input wire logic link_clk,
   input wire logic serial_bit_in,
   input wire logic conv_clk,
   input wire logic transfer_strobe_n,
   input wire logic output_clear_n,
   input wire logic [NUM_CONV-1:0] conv_select_n
);
   int por_cnt;
   // counts power-on cycles since the last reset, saturating
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         por_cnt <= 0;
      end else if (por_cnt < POR_LEN) begin
         por_cnt <= por_cnt + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_inv;
      conv_clk == !link_clk;
   endproperty
   a_inv: assert property (p_inv) else $error("conv clock not inverted");
   property p_data;
      $fell(link_clk) |-> $stable(serial_bit_in);
   endproperty
   a_data: assert property (p_data) else $error("data moved at fall");
   property p_idle;
      !busy |-> !link_clk && conv_clk && transfer_strobe_n;
   endproperty
   a_idle: assert property (p_idle) else $error("idle link not at rest");
   property p_por;
      por_cnt < POR_LEN |-> !output_clear_n;
   endproperty
   a_por: assert property (p_por) else $error("clear released early");
   property p_load;
      $fell(transfer_strobe_n) |-> $rose(link_clk);
   endproperty
   a_load: assert property (p_load) else $error("strobe not on rise");
   property p_hold;
      $rose(transfer_strobe_n) |-> $fell(link_clk);
   endproperty
   a_hold: assert property (p_hold) else $error("strobe end not on fall");
   property p_iso;
      isolated_mode && $past(isolated_mode) && !$past(sys_rst)
         |-> conv_select_n == '0;
   endproperty
   a_iso: assert property (p_iso) else $error("select high in isolation");
   property p_rel;
      |(conv_select_n & ~$past(conv_select_n))
         |-> !link_clk && !$past(link_clk);
   endproperty
   a_rel: assert property (p_rel) else $error("select freed with clock up");
   property p_clr;
      clear_req |=> !output_clear_n;
   endproperty
   a_clr: assert property (p_clr) else $error("clear request ignored");
   property p_done;
      word_done |-> !link_clk && transfer_strobe_n ##1 !word_done;
   endproperty
   a_done: assert property (p_done) else $error("bad word end");
endmodule
bind tdl_host tdl_host_asserts #(.NUM_CONV(NUM_CONV), .POR_LEN(POR_LEN)) i_chk (
   .clk(clk), .sys_rst(sys_rst), .isolated_mode(isolated_mode),
   .clear_req(clear_req), .busy(busy), .word_done(word_done),
   .link_clk(link_clk), .serial_bit_in(serial_bit_in), .conv_clk(conv_clk),
   .transfer_strobe_n(transfer_strobe_n), .output_clear_n(output_clear_n),
   .conv_select_n(conv_select_n)
);

// ---- sim/tdl_host_bench.sv ----
`timescale 1ns/1ps
module tdl_host_bench import tdl_pkg::*; ;
   logic clk, sys_rst, word_valid, isolated_mode, clear_req;
   tdl_word_type word_data;
   logic word_ready, busy, word_done, link_clk, serial_bit_in, conv_clk;
   logic transfer_strobe_n, output_clear_n, limit_converter_select, lsel;
   logic [3:0] conv_select_n;
   wire [DATA_BITS-1:0] lv [4];
   tdl_word_type q [17];
   int err_count = 0;
   int total_checks = 0;
   int done_cnt = 0;

   tdl_host #(.POR_LEN(50), .HALF_LEN(2), .SETTLE_LEN(1)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data),
      .isolated_mode(isolated_mode), .clear_req(clear_req), .busy(busy),
      .word_done(word_done), .link_clk(link_clk),
      .serial_bit_in(serial_bit_in), .conv_clk(conv_clk),
      .transfer_strobe_n(transfer_strobe_n), .output_clear_n(output_clear_n),
      .conv_select_n(conv_select_n),
      .limit_converter_select(limit_converter_select)
   );
   for (genvar g = 0; g < 4; g++) begin : g_conv
      tdl_conv_model i_conv (
         .conv_clk(conv_clk), .serial_bit_in(serial_bit_in),
         .transfer_strobe_n(transfer_strobe_n),
         .output_clear_n(output_clear_n), .select_n(conv_select_n[g]),
         .level(lv[g])
      );
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (word_done === 1'b1) begin
         done_cnt <= done_cnt + 1;
      end
   end
   always @(negedge transfer_strobe_n) begin
      lsel = limit_converter_select;
   end

   task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // holds valid across back-to-back words
   task send(input int n);
      for (int i = 0; i < n; i++) begin
         word_data <= q[i];
         word_valid <= 1'b1;
         @(posedge clk);
      end
      word_valid <= 1'b0;
   endtask
   // a single idle cycle separates queued words, so ask for four
   task wait_idle;
      int k;
      k = 0;
      for (int i = 0; i < 3000 && k < 4; i++) begin
         @(posedge clk);
         k = busy ? 0 : k + 1;
      end
      chk("idle", 12'h000, 12'(k < 4));
      #1;
   endtask

   task t_por;
      chk("clear_n", 12'h000, 12'(output_clear_n));
      chk("conv_clk", 12'h001, 12'(conv_clk));
      wait_idle();
      chk("clear_n", 12'h001, 12'(output_clear_n));
      for (int i = 0; i < 4; i++) chk("level", 12'h000, lv[i]);
      $display("test power-on done");
   endtask
   task t_one;
      int d;
      d = done_cnt;
      q[0] = {2'h2, 12'ha5c};
      send(1);
      wait_idle();
      for (int i = 0; i < 4; i++) chk("level", i == 2 ? 12'ha5c : 12'h000, lv[i]);
      chk("done", 12'h001, 12'(done_cnt - d));
      $display("test single word done");
   endtask
   task t_limits;
      q[0] = {2'h1, 12'hfff};
      q[1] = {2'h0, 12'h001};
      send(2);
      wait_idle();
      chk("upper", 12'hfff, lv[1]);
      chk("lower", 12'h001, lv[0]);
      chk("limit_sel", 12'h000, 12'(lsel));
      chk("other", 12'ha5c, lv[2]);
      $display("test limit pair done");
   endtask
   task t_iso;
      isolated_mode <= 1'b1;
      q[0] = {2'h3, 12'h3c5};
      send(1);
      wait_idle();
      for (int i = 0; i < 4; i++) chk("level", 12'h3c5, lv[i]);
      isolated_mode <= 1'b0;
      $display("test isolated done");
   endtask
   task t_fifo;
      int d;
      clear_req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("clear_n", 12'h000, 12'(output_clear_n));
      for (int i = 0; i < 4; i++) chk("level", 12'h000, lv[i]);
      d = done_cnt;
      for (int i = 0; i < 17; i++) q[i] = {2'h0, 12'(12'h100 + i)};
      send(17);
      #1;
      chk("ready", 12'h000, 12'(word_ready));
      clear_req <= 1'b0;
      wait_idle();
      chk("last", 12'h10f, lv[0]);
      chk("done", 12'h010, 12'(done_cnt - d));
      $display("test queue and clear done");
   endtask

   initial begin
      sys_rst = 1'b1;
      word_valid = 1'b0;
      word_data = '0;
      isolated_mode = 1'b0;
      clear_req = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      t_por();
      t_one();
      t_limits();
      t_iso();
      t_fifo();
      end_sim();
   end
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
endmodule
